//--- hdl/vgagc_pkg.sv
// Shared constants, field layouts and carrier types of the graphics controller register bank.
package vgagc_pkg;

  // I/O port addresses.
  localparam logic [15:0] IO_GFX_INDEX     = 16'h03CE;
  localparam logic [15:0] IO_GFX_DATA      = 16'h03CF;
  localparam logic [15:0] IO_CRTC_INDEX_M  = 16'h03B4;
  localparam logic [15:0] IO_CRTC_DATA_M   = 16'h03B5;
  localparam logic [15:0] IO_CRTC_INDEX_C  = 16'h03D4;
  localparam logic [15:0] IO_CRTC_DATA_C   = 16'h03D5;

  // Graphics register indices.
  localparam logic [5:0] IDX_SET_RESET_BACKGROUND       = 6'h00;
  localparam logic [5:0] IDX_SET_RESET_ENABLE_FOREGROUND = 6'h01;
  localparam logic [5:0] IDX_COLOR_COMPARE_VALUE        = 6'h02;
  localparam logic [5:0] IDX_ROTATE_AND_LOGIC_FUNCTION  = 6'h03;
  localparam logic [5:0] IDX_READ_PLANE_SELECT          = 6'h04;
  localparam logic [5:0] IDX_READ_WRITE_MODE_CONTROL    = 6'h05;

  // CRTC readback indices.
  localparam logic [7:0] IDX_DATA_LATCH_READBACK  = 8'h22;
  localparam logic [7:0] IDX_ATTR_TOGGLE_READBACK = 8'h24;
  localparam logic [7:0] IDX_ATTR_INDEX_READBACK  = 8'h26;

  // Field positions.
  localparam int GFX_INDEX_MSB   = 5;
  localparam int LOW_NIBBLE_MSB  = 3;
  localparam int LOGIC_FN_MSB    = 4;
  localparam int LOGIC_FN_LSB    = 3;
  localparam int ROTATE_MSB      = 2;
  localparam int PLANE_SEL_MSB   = 1;
  localparam int MODE_256_COLOR  = 6;
  localparam int MODE_SHIFT_REG  = 5;
  localparam int MODE_ODD_EVEN   = 4;
  localparam int MODE_READ       = 3;
  localparam int MODE_WRITE_MSB  = 2;
  localparam int TOGGLE_BIT      = 7;
  localparam int VIDEO_EN_BIT    = 5;

  // Writable masks and reset values.
  localparam logic [7:0] MASK_COLOR_COMPARE = 8'h0F;
  localparam logic [7:0] MASK_ROTATE_LOGIC  = 8'h1F;
  localparam logic [7:0] MASK_PLANE_SELECT  = 8'h03;
  localparam logic [7:0] MASK_MODE          = 8'h7F;
  localparam logic [7:0] MASK_HIGH_NIBBLE   = 8'hF0;
  localparam logic [7:0] REG_RESET          = 8'h00;

  typedef enum logic [2:0] {
    WMODE_0 = 3'h0, WMODE_1 = 3'h1, WMODE_2 = 3'h2, WMODE_3 = 3'h3,
    WMODE_4 = 3'h4, WMODE_5 = 3'h5, WMODE_R6 = 3'h6, WMODE_R7 = 3'h7
  } vgagc_wmode_t;

  typedef enum logic [1:0] {
    LFN_PASS = 2'h0, LFN_AND = 2'h1, LFN_OR = 2'h2, LFN_XOR = 2'h3
  } vgagc_lfn_t;

  // One host I/O cycle.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } vgagc_io_req_t;

  // Result of one CPU write to display memory.
  typedef struct packed {
    logic [31:0] plane_data;
    logic [7:0]  bit_mask;
    logic        ext_pixels;
    logic [63:0] pixel_color;
    logic [7:0]  pixel_wen;
  } vgagc_wr_out_t;

  // Byte of plane n out of four packed planes.
  function automatic logic [7:0] plane_byte(input logic [31:0] planes, input logic [1:0] sel);
    plane_byte = planes[{sel, 3'h0} +: 8];
  endfunction : plane_byte

endpackage : vgagc_pkg

//--- hdl/vgagc_read_unit.sv
// Read path: plane select for read mode 0 and colour compare for read mode 1.
module vgagc_read_unit (
  input  wire logic [31:0] planes,
  input  wire logic        read_mode,
  input  wire logic [1:0]  plane_sel,
  input  wire logic [3:0]  cmp_value,
  input  wire logic [3:0]  dont_care,
  output logic      [7:0]  rd_data
);

  logic [7:0] cmp_bits;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // A plane whose mask bit is clear is forced to match.
      cmp_bits[i] = &(~({planes[24 + i], planes[16 + i], planes[8 + i], planes[i]} ^ cmp_value)
                      | ~dont_care);
    end
  end

  assign rd_data = read_mode ? cmp_bits
                             : vgagc_pkg::plane_byte(planes, plane_sel);

endmodule : vgagc_read_unit

//--- hdl/vgagc_regs.sv
// Graphics controller register bank with latch, attribute readback and memory data paths.
//
// Operation
// - Latch readback returns one of four latches chosen by plane select bits.
// - Every CPU display memory read loads all four data latches.
// - Latch readback is an 8-bit read-only byte.
// - Toggle readback bit 7 shows attribute flip-flop; other bits read zero.
// - Index readback shows video enable in bit 5, index in bits 4..0.
// - Index at port 3CE selects the register reached through port 3CF.
// - In extended write mode 5 all set/reset bits give the background.
// - Set/reset high nibble gated by extension enable: ignored and zero when off.
// - Set/reset low nibble gives plane values for write modes 0 and 3.
// - Set/reset-enable gives the foreground colour in extended modes 4 and 5.
// - Set/reset-enable high nibble has the same extension gating.
// - Write mode 0: enable bit picks set/reset value, else CPU data.
// - Read mode 1 compares colour value against eight pixels and returns results.
// - Planes excluded by the don't-care mask always match.
// - Write mode 0 logic function: pass, AND, OR or XOR with latches.
// - CPU data is rotated by 0 to 7 before set/reset.
// - Plane select picks plane n for read mode 0.
// - Mode register holds 256-colour, shift, odd/even, read and write mode fields.
// - Extension enable off forces the top write mode bit to zero.
// - Compare result bit is 1 when compared plane bits equal the value.
// - Extended mode 4 writes foreground only where CPU data bit is 1.
// - Extended mode 5 writes foreground where data is 1, background where 0.
module vgagc_regs (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  // Host I/O cycle.
  input  wire vgagc_pkg::vgagc_io_req_t io_req,
  output logic                          io_rvalid,
  output logic [7:0]                    io_rdata,
  // State owned by neighbouring blocks on the same clock.
  input  wire logic                     ext_enable,
  input  wire logic [3:0]               color_dont_care_mask,
  input  wire logic                     attr_toggle,
  input  wire logic [5:0]               attribute_index_register,
  // CPU access to display memory.
  input  wire logic                     mem_rd,
  input  wire logic [31:0]              mem_rd_planes,
  input  wire logic                     mem_wr,
  input  wire logic [7:0]               mem_wr_data,
  output logic                          cpu_rd_valid,
  output logic [7:0]                    cpu_rd_data,
  output logic                          mem_wr_valid,
  output vgagc_pkg::vgagc_wr_out_t      mem_wr_out,
  // Mode fields for the display pipeline.
  output logic                          mode_256_color,
  output logic                          mode_shift_cga,
  output logic                          mode_odd_even
);

  logic [5:0]  gfx_index_r;
  logic [7:0]  crtc_index_r;
  logic [7:0]  set_reset_background_r;
  logic [7:0]  set_reset_enable_foreground_r;
  logic [7:0]  color_compare_value_r;
  logic [7:0]  rotate_and_logic_function_r;
  logic [7:0]  read_plane_select_r;
  logic [7:0]  read_write_mode_control_r;
  logic [31:0] latches_r;

  logic        gfx_index_hit;
  logic        gfx_data_hit;
  logic        crtc_index_hit;
  logic        crtc_data_hit;
  logic        gfx_wr;
  logic [2:0]  eff_wmode;
  logic [7:0]  eff_mode;
  logic [7:0]  high_keep;
  logic [7:0]  gfx_rd_nxt;
  logic [7:0]  crtc_rd_nxt;
  logic [7:0]  io_rdata_nxt;
  logic [7:0]  cpu_rd_nxt;
  vgagc_pkg::vgagc_wr_out_t wr_nxt;

  // Address decode. Both the monochrome and colour CRTC port pairs are answered.
  assign gfx_index_hit  = io_req.addr == vgagc_pkg::IO_GFX_INDEX;
  assign gfx_data_hit   = io_req.addr == vgagc_pkg::IO_GFX_DATA;
  assign crtc_index_hit = (io_req.addr == vgagc_pkg::IO_CRTC_INDEX_M) ||
                          (io_req.addr == vgagc_pkg::IO_CRTC_INDEX_C);
  assign crtc_data_hit  = (io_req.addr == vgagc_pkg::IO_CRTC_DATA_M) ||
                          (io_req.addr == vgagc_pkg::IO_CRTC_DATA_C);
  assign gfx_wr         = io_req.wr && gfx_data_hit;

  // The stored top write mode bit is kept, but masked while extensions are off.
  assign eff_wmode = {read_write_mode_control_r[vgagc_pkg::MODE_WRITE_MSB] & ext_enable,
                      read_write_mode_control_r[vgagc_pkg::MODE_WRITE_MSB - 1:0]};
  assign eff_mode  = {read_write_mode_control_r[7:3], eff_wmode};

  // High nibble of the two colour registers only exists while extensions are on.
  assign high_keep = ext_enable ? 8'hFF : ~vgagc_pkg::MASK_HIGH_NIBBLE;

  // Graphics index register.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gfx_index_r <= 6'h00;
    end else if (clk_en && io_req.wr && gfx_index_hit) begin
      gfx_index_r <= io_req.wdata[vgagc_pkg::GFX_INDEX_MSB:0];
    end
  end

  // CRTC index register, used here only to reach the readback registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      crtc_index_r <= 8'h00;
    end else if (clk_en && io_req.wr && crtc_index_hit) begin
      crtc_index_r <= io_req.wdata;
    end
  end

  // Set/reset and set/reset-enable registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      set_reset_background_r        <= vgagc_pkg::REG_RESET;
      set_reset_enable_foreground_r <= vgagc_pkg::REG_RESET;
    end else if (clk_en && gfx_wr) begin
      if (gfx_index_r == vgagc_pkg::IDX_SET_RESET_BACKGROUND) begin
        // A write with extensions off leaves the stored high nibble alone.
        set_reset_background_r <= (io_req.wdata & high_keep) |
                                  (set_reset_background_r & ~high_keep);
      end
      if (gfx_index_r == vgagc_pkg::IDX_SET_RESET_ENABLE_FOREGROUND) begin
        set_reset_enable_foreground_r <= (io_req.wdata & high_keep) |
                                         (set_reset_enable_foreground_r & ~high_keep);
      end
    end
  end

  // Compare, rotate/function, plane select and mode registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      color_compare_value_r       <= vgagc_pkg::REG_RESET;
      rotate_and_logic_function_r <= vgagc_pkg::REG_RESET;
      read_plane_select_r         <= vgagc_pkg::REG_RESET;
      read_write_mode_control_r   <= vgagc_pkg::REG_RESET;
    end else if (clk_en && gfx_wr) begin
      case (gfx_index_r)
        vgagc_pkg::IDX_COLOR_COMPARE_VALUE:
          color_compare_value_r <= io_req.wdata & vgagc_pkg::MASK_COLOR_COMPARE;
        vgagc_pkg::IDX_ROTATE_AND_LOGIC_FUNCTION:
          rotate_and_logic_function_r <= io_req.wdata & vgagc_pkg::MASK_ROTATE_LOGIC;
        vgagc_pkg::IDX_READ_PLANE_SELECT:
          read_plane_select_r <= io_req.wdata & vgagc_pkg::MASK_PLANE_SELECT;
        vgagc_pkg::IDX_READ_WRITE_MODE_CONTROL:
          read_write_mode_control_r <= io_req.wdata & vgagc_pkg::MASK_MODE;
        default: begin
        end
      endcase
    end
  end

  // Data latches follow every CPU read of display memory.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latches_r <= 32'h0000_0000;
    end else if (clk_en && mem_rd) begin
      latches_r <= mem_rd_planes;
    end
  end

  // Graphics data port readback. Unmapped indices read zero.
  always_comb begin
    case (gfx_index_r)
      vgagc_pkg::IDX_SET_RESET_BACKGROUND:        gfx_rd_nxt = set_reset_background_r & high_keep;
      vgagc_pkg::IDX_SET_RESET_ENABLE_FOREGROUND: gfx_rd_nxt = set_reset_enable_foreground_r & high_keep;
      vgagc_pkg::IDX_COLOR_COMPARE_VALUE:         gfx_rd_nxt = color_compare_value_r;
      vgagc_pkg::IDX_ROTATE_AND_LOGIC_FUNCTION:   gfx_rd_nxt = rotate_and_logic_function_r;
      vgagc_pkg::IDX_READ_PLANE_SELECT:           gfx_rd_nxt = read_plane_select_r;
      vgagc_pkg::IDX_READ_WRITE_MODE_CONTROL:     gfx_rd_nxt = eff_mode;
      default:                                    gfx_rd_nxt = 8'h00;
    endcase
  end

  // CRTC readback registers. They have no write path at all.
  always_comb begin
    case (crtc_index_r)
      vgagc_pkg::IDX_DATA_LATCH_READBACK:
        crtc_rd_nxt = vgagc_pkg::plane_byte(latches_r,
                        read_plane_select_r[vgagc_pkg::PLANE_SEL_MSB:0]);
      vgagc_pkg::IDX_ATTR_TOGGLE_READBACK:
        crtc_rd_nxt = {attr_toggle, 7'h00};
      vgagc_pkg::IDX_ATTR_INDEX_READBACK:
        crtc_rd_nxt = {2'h0, attribute_index_register};
      default:
        crtc_rd_nxt = 8'h00;
    endcase
  end

  always_comb begin
    if (gfx_data_hit) begin
      io_rdata_nxt = gfx_rd_nxt;
    end else if (gfx_index_hit) begin
      io_rdata_nxt = {2'h0, gfx_index_r};
    end else if (crtc_data_hit) begin
      io_rdata_nxt = crtc_rd_nxt;
    end else if (crtc_index_hit) begin
      io_rdata_nxt = crtc_index_r;
    end else begin
      io_rdata_nxt = 8'h00;
    end
  end

  // I/O read answer, one cycle after the request, held until the next read.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rvalid <= 1'b0;
      io_rdata  <= 8'h00;
    end else if (clk_en) begin
      io_rvalid <= io_req.rd;
      if (io_req.rd) begin
        io_rdata <= io_rdata_nxt;
      end
    end
  end

  // The read answer is formed from the freshly fetched planes, not the old latches.
  vgagc_read_unit u_read (
    .planes    (mem_rd_planes),
    .read_mode (read_write_mode_control_r[vgagc_pkg::MODE_READ]),
    .plane_sel (read_plane_select_r[vgagc_pkg::PLANE_SEL_MSB:0]),
    .cmp_value (color_compare_value_r[vgagc_pkg::LOW_NIBBLE_MSB:0]),
    .dont_care (color_dont_care_mask),
    .rd_data   (cpu_rd_nxt)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rd_valid <= 1'b0;
      cpu_rd_data  <= 8'h00;
    end else if (clk_en) begin
      cpu_rd_valid <= mem_rd;
      if (mem_rd) begin
        cpu_rd_data <= cpu_rd_nxt;
      end
    end
  end

  // Writes combine with the latches as they stood before this cycle.
  vgagc_write_unit u_write (
    .cpu_data  (mem_wr_data),
    .latches   (latches_r),
    .wmode     (eff_wmode),
    .set_reset (set_reset_background_r),
    .sr_enable (set_reset_enable_foreground_r),
    .rot_fn    (rotate_and_logic_function_r[vgagc_pkg::LOGIC_FN_MSB:0]),
    .wr_out    (wr_nxt)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_wr_valid <= 1'b0;
      mem_wr_out   <= '0;
    end else if (clk_en) begin
      mem_wr_valid <= mem_wr;
      if (mem_wr) begin
        mem_wr_out <= wr_nxt;
      end
    end
  end

  // Mode fields, registered so the outputs come straight from flops.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_256_color <= 1'b0;
      mode_shift_cga <= 1'b0;
      mode_odd_even  <= 1'b0;
    end else if (clk_en) begin
      mode_256_color <= read_write_mode_control_r[vgagc_pkg::MODE_256_COLOR];
      mode_shift_cga <= read_write_mode_control_r[vgagc_pkg::MODE_SHIFT_REG];
      mode_odd_even  <= read_write_mode_control_r[vgagc_pkg::MODE_ODD_EVEN];
    end
  end

endmodule : vgagc_regs

//--- hdl/vgagc_write_unit.sv
// Write path: rotator, set/reset, logic function and the write modes 0 to 5.
module vgagc_write_unit (
  input  wire logic [7:0]           cpu_data,
  input  wire logic [31:0]          latches,
  input  wire logic [2:0]           wmode,
  input  wire logic [7:0]           set_reset,
  input  wire logic [7:0]           sr_enable,
  input  wire logic [4:0]           rot_fn,
  output vgagc_pkg::vgagc_wr_out_t  wr_out
);

  logic [7:0]  rotated;
  logic [15:0] doubled;
  logic [7:0]  src;
  logic [7:0]  lat;

  assign doubled = {cpu_data, cpu_data};
  assign rotated = doubled[rot_fn[2:0] +: 8];

  always_comb begin
    wr_out = '0;
    src    = 8'h00;
    lat    = 8'h00;
    case (vgagc_pkg::vgagc_wmode_t'(wmode))
      vgagc_pkg::WMODE_0: begin
        wr_out.bit_mask = 8'hFF;
        for (int p = 0; p < 4; p++) begin
          src = sr_enable[p] ? {8{set_reset[p]}} : rotated;
          lat = latches[8 * p +: 8];
          case (vgagc_pkg::vgagc_lfn_t'(rot_fn[4:3]))
            vgagc_pkg::LFN_AND: wr_out.plane_data[8 * p +: 8] = src & lat;
            vgagc_pkg::LFN_OR:  wr_out.plane_data[8 * p +: 8] = src | lat;
            vgagc_pkg::LFN_XOR: wr_out.plane_data[8 * p +: 8] = src ^ lat;
            default:            wr_out.plane_data[8 * p +: 8] = src;
          endcase
        end
      end
      vgagc_pkg::WMODE_1: begin
        wr_out.bit_mask   = 8'hFF;
        wr_out.plane_data = latches;
      end
      vgagc_pkg::WMODE_2: begin
        wr_out.bit_mask = 8'hFF;
        for (int p = 0; p < 4; p++) wr_out.plane_data[8 * p +: 8] = {8{cpu_data[p]}};
      end
      vgagc_pkg::WMODE_3: begin
        wr_out.bit_mask = rotated;
        for (int p = 0; p < 4; p++) wr_out.plane_data[8 * p +: 8] = {8{set_reset[p]}};
      end
      vgagc_pkg::WMODE_4: begin
        wr_out.ext_pixels  = 1'b1;
        wr_out.pixel_wen   = cpu_data;
        wr_out.pixel_color = {8{sr_enable}};
      end
      vgagc_pkg::WMODE_5: begin
        wr_out.ext_pixels = 1'b1;
        wr_out.pixel_wen  = 8'hFF;
        for (int i = 0; i < 8; i++) begin
          wr_out.pixel_color[8 * i +: 8] = cpu_data[i] ? sr_enable : set_reset;
        end
      end
      default: wr_out = '0;
    endcase
  end

endmodule : vgagc_write_unit

//--- tb/vgagc_host.sv
// Host model that issues I/O port cycles to the register bank.
module vgagc_host (
  input  wire logic              sys_clk,
  input  wire logic              io_rvalid,
  input  wire logic [7:0]        io_rdata,
  output vgagc_pkg::vgagc_io_req_t io_req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial io_req = '0;

  // A released bus shows inverted address and data, so nothing can pass on a stale value.
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    io_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge sys_clk);
    #1;
    io_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : io_wr

  // The answer stands for exactly the cycle after the taking edge.
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(posedge sys_clk);
    #1;
    io_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    #1;
    io_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
    ok = io_rvalid;
    d = io_rdata;
  endtask : io_rd

  task automatic gw(input logic [5:0] i, input logic [7:0] d);
    io_wr(16'h03CE, {2'h0, i});
    io_wr(16'h03CF, d);
  endtask : gw
endmodule : vgagc_host

//--- tb/vgagc_regs_checker.sv
// Concurrent checks on the ports of the graphics controller register bank.
module vgagc_regs_checker (
  input wire logic                     sys_clk,
  input wire logic                     rst_n,
  input wire logic                     clk_en,
  input wire vgagc_pkg::vgagc_io_req_t io_req,
  input wire logic                     io_rvalid,
  input wire logic [7:0]               io_rdata,
  input wire logic                     ext_enable,
  input wire logic [3:0]               color_dont_care_mask,
  input wire logic                     attr_toggle,
  input wire logic [5:0]               attribute_index_register,
  input wire logic                     mem_rd,
  input wire logic [31:0]              mem_rd_planes,
  input wire logic                     mem_wr,
  input wire logic [7:0]               mem_wr_data,
  input wire logic                     cpu_rd_valid,
  input wire logic [7:0]               cpu_rd_data,
  input wire logic                     mem_wr_valid,
  input wire vgagc_pkg::vgagc_wr_out_t mem_wr_out,
  input wire logic                     mode_256_color,
  input wire logic                     mode_shift_cga,
  input wire logic                     mode_odd_even
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_rd_ans; clk_en && io_req.rd |=> io_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("io read not answered");
  property p_rd_src; io_rvalid && $past(clk_en) |-> $past(io_req.rd); endproperty
  a_rd_src: assert property (p_rd_src) else $error("io answer without read");
  property p_mrd; clk_en && mem_rd |=> cpu_rd_valid; endproperty
  a_mrd: assert property (p_mrd) else $error("memory read not answered");
  property p_mrd_src; cpu_rd_valid && $past(clk_en) |-> $past(mem_rd); endproperty
  a_mrd_src: assert property (p_mrd_src) else $error("memory answer without read");
  property p_mwr; clk_en && mem_wr |=> mem_wr_valid; endproperty
  a_mwr: assert property (p_mwr) else $error("memory write not answered");
  property p_ext_off; clk_en && mem_wr && !ext_enable |=> !mem_wr_out.ext_pixels; endproperty
  a_ext_off: assert property (p_ext_off) else $error("extended mode without extension");
  property p_ext_wen;
    mem_wr_valid && mem_wr_out.ext_pixels |-> mem_wr_out.bit_mask == 8'h00 &&
      (mem_wr_out.pixel_wen == 8'hFF || mem_wr_out.pixel_wen == $past(mem_wr_data));
  endproperty
  a_ext_wen: assert property (p_ext_wen) else $error("pixel enables wrong");
  property p_mode_src;
    $changed({mode_256_color, mode_shift_cga, mode_odd_even}) |->
      $past(io_req.wr, 2) && $past(io_req.addr, 2) == vgagc_pkg::IO_GFX_DATA;
  endproperty
  a_mode_src: assert property (p_mode_src) else $error("mode bits moved unwritten");
  property p_wr_hold; !$past(clk_en && mem_wr) |-> $stable(mem_wr_out); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write result not held");
  property p_rd_hold; !$past(clk_en && io_req.rd) |-> $stable(io_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("io read data not held");
  c_rd: cover property (clk_en && io_req.rd ##1 io_rvalid);
  c_mrd: cover property (clk_en && mem_rd ##1 cpu_rd_valid);
  c_ext: cover property (mem_wr_valid && mem_wr_out.ext_pixels);
endmodule : vgagc_regs_checker

bind vgagc_regs vgagc_regs_checker i_chk (.sys_clk, .rst_n, .clk_en, .io_req, .io_rvalid, .io_rdata,
  .ext_enable, .color_dont_care_mask, .attr_toggle, .attribute_index_register, .mem_rd, .mem_rd_planes,
  .mem_wr, .mem_wr_data, .cpu_rd_valid, .cpu_rd_data, .mem_wr_valid, .mem_wr_out, .mode_256_color,
  .mode_shift_cga, .mode_odd_even);

//--- tb/vgagc_regs_tb.sv
// Self-checking bench of the graphics controller register bank.
module vgagc_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     sys_clk = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     clk_en = 1'b1;
  logic                     ext_en = 1'b0;
  logic [3:0]               msk = 4'hF;
  logic                     tgl = 1'b0;
  logic [5:0]               aidx = 6'h00;
  logic                     mem_rd = 1'b0;
  logic                     mem_wr = 1'b0;
  logic [31:0]              planes = 32'h0;
  logic [7:0]               wdat = 8'h00;
  vgagc_pkg::vgagc_io_req_t io_req;
  vgagc_pkg::vgagc_wr_out_t wo;
  logic                     io_rvalid, cpu_rd_valid, mem_wr_valid, m256, mshift, moe;
  logic [7:0]               io_rdata, cpu_rd_data;
  int                       bad_count = 0;
  int                       n_checks = 0;

  vgagc_regs i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .io_req(io_req),
    .io_rvalid(io_rvalid), .io_rdata(io_rdata), .ext_enable(ext_en), .color_dont_care_mask(msk),
    .attr_toggle(tgl), .attribute_index_register(aidx), .mem_rd(mem_rd), .mem_rd_planes(planes),
    .mem_wr(mem_wr), .mem_wr_data(wdat), .cpu_rd_valid(cpu_rd_valid), .cpu_rd_data(cpu_rd_data),
    .mem_wr_valid(mem_wr_valid), .mem_wr_out(wo), .mode_256_color(m256), .mode_shift_cga(mshift),
    .mode_odd_even(moe));
  vgagc_host i_host (.sys_clk(sys_clk), .io_rvalid(io_rvalid), .io_rdata(io_rdata), .io_req(io_req));

  always #4 sys_clk = ~sys_clk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic fail_hang();
    bad_count++;
    close_out();
  endtask : fail_hang

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic rdc(input logic [15:0] a, output logic [7:0] d);
    logic ok;
    i_host.io_rd(a, d, ok);
    if (ok !== 1'b1) fail_hang();
  endtask : rdc

  task automatic gr(input logic [5:0] i, input logic [7:0] e);
    logic [7:0] d;
    i_host.io_wr(16'h03CE, {2'h0, i});
    rdc(16'h03CF, d);
    chk(64'(d), 64'(e));
  endtask : gr

  // One memory cycle; a write carries its byte in the low bits of p.
  task automatic mem_op(input logic w, input logic [31:0] p);
    @(posedge sys_clk);
    #1;
    {mem_wr, mem_rd, planes, wdat} = {w, ~w, w ? ~p : p, p[7:0]};
    @(posedge sys_clk);
    #1;
    {mem_wr, mem_rd, planes, wdat} = {2'b00, ~p, ~p[7:0]};
    if ((w ? mem_wr_valid : cpu_rd_valid) !== 1'b1) fail_hang();
  endtask : mem_op

  task automatic t_regs();
    logic [7:0] lo [6] = '{8'h0F, 8'h0F, 8'h0F, 8'h1F, 8'h03, 8'h7B};
    logic [7:0] d;
    for (int i = 0; i < 6; i++) gr(i[5:0], 8'h00);
    for (int i = 0; i < 6; i++) begin
      i_host.gw(i[5:0], 8'hFF);
      gr(i[5:0], lo[i]);
    end
    chk(64'({m256, mshift, moe}), 64'h7);
    i_host.io_wr(16'h03CE, 8'hFF);
    rdc(16'h03CE, d);
    chk(64'(d), 64'h3F);
    rdc(16'h03CF, d);
    chk(64'(d), 64'h00);
    ext_en = 1'b1;
    i_host.gw(6'h00, 8'hFF);
    gr(6'h00, 8'hFF);
    i_host.gw(6'h01, 8'hFF);
    gr(6'h01, 8'hFF);
    gr(6'h05, 8'h7F);
    ext_en = 1'b0;
    gr(6'h01, 8'h0F);
    i_host.gw(6'h05, 8'h00);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_crtc();
    logic [7:0] d;
    tgl = 1'b1;
    aidx = 6'h2A;
    i_host.io_wr(16'h03D4, 8'h24);
    rdc(16'h03D5, d);
    chk(64'(d), 64'h80);
    i_host.io_wr(16'h03B4, 8'h26);
    i_host.io_wr(16'h03B5, 8'hFF);
    rdc(16'h03B5, d);
    chk(64'(d), 64'h2A);
    tgl = 1'b0;
    aidx = 6'h15;
    i_host.io_wr(16'h03D4, 8'h24);
    rdc(16'h03D5, d);
    chk(64'(d), 64'h00);
    clk_en = 1'b0;
    i_host.io_wr(16'h03D4, 8'h26);
    clk_en = 1'b1;
    rdc(16'h03D5, d);
    chk(64'(d), 64'h00);
    $display("t_crtc done");
  endtask : t_crtc

  task automatic t_read();
    logic [7:0] d;
    logic [31:0] p = 32'hC3A55A3C;
    logic [3:0] mk [3] = '{4'hF, 4'h5, 4'h0};
    logic [7:0] ex [3] = '{8'h40, 8'hC0, 8'hFF};
    for (int n = 0; n < 4; n++) begin
      i_host.gw(6'h04, 8'(n));
      mem_op(1'b0, p);
      chk(64'(cpu_rd_data), 64'(p[8*n +: 8]));
      i_host.io_wr(16'h03D4, 8'h22);
      i_host.io_wr(16'h03D5, 8'h00);
      rdc(16'h03D5, d);
      chk(64'(d), 64'(p[8*n +: 8]));
      p = {p[23:0], p[31:24]} ^ 32'h0F0F0F0F;
    end
    i_host.gw(6'h05, 8'h08);
    i_host.gw(6'h02, 8'h0A);
    for (int k = 0; k < 3; k++) begin
      msk = mk[k];
      mem_op(1'b0, 32'hF033550F);
      chk(64'(cpu_rd_data), 64'(ex[k]));
    end
    i_host.gw(6'h05, 8'h00);
    $display("t_read done");
  endtask : t_read

  task automatic t_write();
    logic [7:0] s, l, e;
    logic [31:0] lat = 32'h9C6B3A17;
    i_host.gw(6'h00, 8'h05);
    i_host.gw(6'h01, 8'h03);
    mem_op(1'b0, lat);
    for (int f = 0; f < 4; f++) begin
      i_host.gw(6'h03, 8'(f * 8 + 1));
      mem_op(1'b1, 32'h81);
      for (int p = 0; p < 4; p++) begin
        s = p < 2 ? {8{p == 0}} : 8'hC0;
        l = lat[8*p +: 8];
        e = f == 0 ? s : f == 1 ? s & l : f == 2 ? s | l : s ^ l;
        chk(64'(wo.plane_data[8*p +: 8]), 64'(e));
      end
    end
    i_host.gw(6'h03, 8'h07);
    i_host.gw(6'h05, 8'h03);
    mem_op(1'b1, 32'h81);
    chk(64'({wo.bit_mask, wo.plane_data}), 64'h03_00FF00FF);
    i_host.gw(6'h05, 8'h05);
    mem_op(1'b1, 32'h81);
    chk(64'({wo.ext_pixels, wo.plane_data}), 64'(lat));
    ext_en = 1'b1;
    i_host.gw(6'h00, 8'h3C);
    i_host.gw(6'h01, 8'hC5);
    i_host.gw(6'h05, 8'h04);
    mem_op(1'b1, 32'hA5);
    chk(64'({wo.ext_pixels, wo.pixel_wen}), 64'h1A5);
    chk(wo.pixel_color, {8{8'hC5}});
    i_host.gw(6'h05, 8'h05);
    mem_op(1'b1, 32'hA5);
    chk(64'(wo.pixel_wen), 64'hFF);
    chk(wo.pixel_color, 64'hC53CC53C3CC53CC5);
    ext_en = 1'b0;
    $display("t_write done");
  endtask : t_write

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_hang();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    t_regs();
    t_crtc();
    t_read();
    t_write();
    close_out();
  end
endmodule : vgagc_regs_tb
